// >>> rtl/mult_block_defs.vh
// Purpose: Constants for the configurable multiplier block
// Assumes: Included by rtl/mult_block.v, the fabric model and the bench
// Notes:   Offsets are byte addresses on the AXI4-Lite register bus
`ifndef MULT_BLOCK_DEFS_VH
`define MULT_BLOCK_DEFS_VH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define MB_ADDR_W 8
`define MB_OFS_CTRL 8'h00
`define MB_OFS_STATUS 8'h04
`define MB_CTRL_RESET 32'h00000000

// ----------------------------------------------------------------
// Control field positions
// ----------------------------------------------------------------
`define MB_CTRL_IN_REG 0
`define MB_CTRL_PIPE 1
`define MB_CTRL_SIGN_REG 2
`define MB_CTRL_LD_LO 3
`define MB_CTRL_LD_HI 4
`define MB_CTRL_NARROW0 5
`define MB_CTRL_NARROW1 6
`define MB_CTRL_CLEAR 8
`define MB_CTRL_MASK 32'h0000007f

// ----------------------------------------------------------------
// Mode codes (mode inputs and effective status)
// ----------------------------------------------------------------
`define MB_MODE_SIMPLE 2'h0
`define MB_MODE_MAC 2'h1
`define MB_MODE_WIDE 2'h2
`define MB_MODE_NINE 2'h3

// ----------------------------------------------------------------
// Bus answers and widths
// ----------------------------------------------------------------
`define MB_RESP_OKAY 2'h0
`define MB_RESP_SLVERR 2'h2
`define MB_LANE_W 18
`define MB_ACC_W 52
`define MB_PRELOAD_W 36
`define MB_PRELOAD_LSB 16

`endif

// >>> rtl/mult_block.v
// Purpose: Configurable hard multiplier block: 9x9, 18x18, 36x36 products and two 52-bit accumulators
// Assumes: Operands and controls come from logic on clk_sys_in; registers over AXI4-Lite
// Notes:   Each half has its own mode input; wide mode needs both halves set to it
//
// How it works
// - A half set narrow runs 9x9 multipliers, otherwise 18x18 multipliers.
// - Narrow halves give eight independent 9x9 products, each in its own slot.
// - Simple 18-bit mode gives four independent 18x18 products, one per lane.
// - Two 52-bit accumulating channels, never at 9x9 or 36x36 size.
// - Halves run different modes at once, sharing each half's sign settings.
// - Run-time choice of simple, accumulate or 36-bit product per mode inputs.
// - Each half owns a mode input and switches independently between simple and accumulate.
// - Mode switching applies only at 18-bit width, never to narrow halves.
// - Per-operand sign flags, mixed allowed, changeable per cycle, optionally registered.
// - Input and pipeline registers individually selectable by control bits.
// - 36x36 built from four 18x18 partial products summed, optional pipeline between.
// - 36x36 handles signed, unsigned and mixed operand pairs.
// - Accumulator is 52 bits, held in the output registers.
// - Load-select restarts accumulation without a lost cycle, delay 0, 1 or 2.
// - Load with preload seeds accumulator bits 51..16 from the preload bus.
// - Bits 37..16 come from preload or product; user zeroes the other.
// - Overflow is re-evaluated every accumulating cycle; no persistence inside.
// - Direction input chooses add or subtract cycle by cycle.
// - Plain accumulator works by driving one operand to one.
// - Direction high adds, low subtracts.
// - Overflow output pulses one cycle on detection, even if condition persists.
// - During load the feedback is replaced by preload value or zero.
// - Clearing the output registers clears the accumulators too.
//
// Implementation choices: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps
`include "mult_block_defs.vh"

module mult_block (
    // Clock, reset, enable
    input wire clk_sys_in,
    input wire reset_n_in,
    input wire clk_en_in,
    // AXI4-Lite write address and data
    input wire awvalid_in,
    output wire awready_out,
    input wire [7:0] awaddr_in,
    input wire wvalid_in,
    output wire wready_out,
    input wire [31:0] wdata_in,
    input wire [3:0] wstrb_in,
    // AXI4-Lite write response
    output wire bvalid_out,
    input wire bready_in,
    output wire [1:0] bresp_out,
    // AXI4-Lite read
    input wire arvalid_in,
    output wire arready_out,
    input wire [7:0] araddr_in,
    output wire rvalid_out,
    input wire rready_in,
    output wire [31:0] rdata_out,
    output wire [1:0] rresp_out,
    // Operands: four 18-bit lanes, lanes 0-1 are half 0, lanes 2-3 half 1
    input wire [71:0] opa_in,
    input wire [71:0] opb_in,
    input wire [1:0] sign_a_in,
    input wire [1:0] sign_b_in,
    input wire [3:0] half_mode_in,
    // Accumulator controls, one per channel
    input wire [1:0] accum_dir_in,
    input wire [1:0] accum_load_in,
    input wire [71:0] preload_in,
    // Results
    output wire [143:0] product_out,
    output wire [103:0] accum_out,
    output wire [1:0] overflow_out
);

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    // 18x18 with optional sign on each operand; 38-bit signed result is exact
    function signed [37:0] mul18;
        input [17:0] a;
        input [17:0] b;
        input sa;
        input sb;
        reg signed [18:0] x;
        reg signed [18:0] y;
        begin
            x = {sa & a[17], a};
            y = {sb & b[17], b};
            mul18 = x * y;
        end
    endfunction

    // 9x9 with optional signs, 18-bit full product
    function [17:0] mul9;
        input [8:0] a;
        input [8:0] b;
        input sa;
        input sb;
        reg signed [9:0] x;
        reg signed [9:0] y;
        reg signed [19:0] p;
        begin
            x = {sa & a[8], a};
            y = {sb & b[8], b};
            p = x * y;
            mul9 = p[17:0];
        end
    endfunction

    // Register decode shared by both bus directions
    function addr_ok;
        input [7:0] a;
        begin
            addr_ok = (a == `MB_OFS_CTRL) || (a == `MB_OFS_STATUS);
        end
    endfunction

    // ----------------------------------------------------------------
    // Control register and bus slave
    // ----------------------------------------------------------------
    reg [6:0] ctrl_r;
    reg clear_r;
    reg aw_hold_r;
    reg [7:0] awaddr_r;
    reg w_hold_r;
    reg [31:0] wdata_r;
    reg [3:0] wstrb_r;
    reg bvalid_r;
    reg [1:0] bresp_r;
    reg rvalid_r;
    reg [31:0] rdata_r;
    reg [1:0] rresp_r;
    wire [31:0] status_w;

    // Ready drops while the block is frozen so no handshake is lost
    assign awready_out = clk_en_in & ~aw_hold_r & ~bvalid_r;
    assign wready_out = clk_en_in & ~w_hold_r & ~bvalid_r;
    assign arready_out = clk_en_in & ~rvalid_r;
    assign bvalid_out = bvalid_r;
    assign bresp_out = bresp_r;
    assign rvalid_out = rvalid_r;
    assign rdata_out = rdata_r;
    assign rresp_out = rresp_r;

    wire aw_now = aw_hold_r | (awvalid_in & awready_out);
    wire w_now = w_hold_r | (wvalid_in & wready_out);
    wire [7:0] waddr = aw_hold_r ? awaddr_r : awaddr_in;
    wire [31:0] wdata = w_hold_r ? wdata_r : wdata_in;
    wire [3:0] wstrb = w_hold_r ? wstrb_r : wstrb_in;
    wire do_write = clk_en_in & aw_now & w_now & ~bvalid_r;
    wire ctrl_hit = do_write & (waddr == `MB_OFS_CTRL);

    always @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ctrl_r <= 7'h00;
            clear_r <= 1'b0;
            aw_hold_r <= 1'b0;
            awaddr_r <= 8'h00;
            w_hold_r <= 1'b0;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= 2'h0;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h00000000;
            rresp_r <= 2'h0;
        end else if (clk_en_in) begin
            clear_r <= ctrl_hit & wstrb[1] & wdata[`MB_CTRL_CLEAR];
            if (do_write) begin
                aw_hold_r <= 1'b0;
                w_hold_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= addr_ok(waddr) ? `MB_RESP_OKAY : `MB_RESP_SLVERR;
                if (ctrl_hit && wstrb[0]) begin
                    ctrl_r <= wdata[6:0];
                end
            end else begin
                if (awvalid_in && awready_out) begin
                    aw_hold_r <= 1'b1;
                    awaddr_r <= awaddr_in;
                end
                if (wvalid_in && wready_out) begin
                    w_hold_r <= 1'b1;
                    wdata_r <= wdata_in;
                    wstrb_r <= wstrb_in;
                end
                if (bvalid_r && bready_in) begin
                    bvalid_r <= 1'b0;
                end
            end
            if (arvalid_in && arready_out) begin
                rvalid_r <= 1'b1;
                rresp_r <= addr_ok(araddr_in) ? `MB_RESP_OKAY : `MB_RESP_SLVERR;
                if (araddr_in == `MB_OFS_CTRL) begin
                    rdata_r <= {25'h0000000, ctrl_r};
                end else if (araddr_in == `MB_OFS_STATUS) begin
                    rdata_r <= status_w;
                end else begin
                    rdata_r <= 32'h00000000;
                end
            end else if (rvalid_r && rready_in) begin
                rvalid_r <= 1'b0;
            end
        end
    end

    wire in_reg_en = ctrl_r[`MB_CTRL_IN_REG];
    wire pipe_en = ctrl_r[`MB_CTRL_PIPE];
    wire sign_reg_en = ctrl_r[`MB_CTRL_SIGN_REG];
    wire [1:0] load_dly = ctrl_r[`MB_CTRL_LD_HI:`MB_CTRL_LD_LO];
    wire [1:0] narrow = {ctrl_r[`MB_CTRL_NARROW1], ctrl_r[`MB_CTRL_NARROW0]};

    // ----------------------------------------------------------------
    // Mode decode
    // ----------------------------------------------------------------
    // Wide mode only when the fabric sets both halves to it together
    wire full36 = ~|narrow && (half_mode_in[1:0] == `MB_MODE_WIDE) &&
        (half_mode_in[3:2] == `MB_MODE_WIDE);
    reg [3:0] mode_now;
    integer h;
    always @* begin
        mode_now = 4'h0;
        for (h = 0; h < 2; h = h + 1) begin
            if (narrow[h]) begin
                mode_now[2*h +: 2] = `MB_MODE_NINE;
            end else if (full36) begin
                mode_now[2*h +: 2] = `MB_MODE_WIDE;
            end else if (half_mode_in[2*h +: 2] == `MB_MODE_MAC) begin
                mode_now[2*h +: 2] = `MB_MODE_MAC;
            end else begin
                mode_now[2*h +: 2] = `MB_MODE_SIMPLE;
            end
        end
    end

    // ----------------------------------------------------------------
    // Input stage (optional registers)
    // ----------------------------------------------------------------
    reg [71:0] opa_r;
    reg [71:0] opb_r;
    reg [1:0] sa_r;
    reg [1:0] sb_r;
    reg [3:0] mode_r;
    reg [1:0] dir_r;
    always @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            opa_r <= 72'h0;
            opb_r <= 72'h0;
            sa_r <= 2'h0;
            sb_r <= 2'h0;
            mode_r <= 4'h0;
            dir_r <= 2'h0;
        end else if (clk_en_in) begin
            opa_r <= opa_in;
            opb_r <= opb_in;
            sa_r <= sign_a_in;
            sb_r <= sign_b_in;
            mode_r <= mode_now;
            dir_r <= accum_dir_in;
        end
    end

    wire [71:0] opa_s = in_reg_en ? opa_r : opa_in;
    wire [71:0] opb_s = in_reg_en ? opb_r : opb_in;
    wire [3:0] mode_s = in_reg_en ? mode_r : mode_now;
    wire [1:0] dir_s = in_reg_en ? dir_r : accum_dir_in;
    wire [1:0] sa_s = sign_reg_en ? sa_r : sign_a_in;
    wire [1:0] sb_s = sign_reg_en ? sb_r : sign_b_in;

    // ----------------------------------------------------------------
    // Multiplier lanes
    // ----------------------------------------------------------------
    wire [151:0] lane_res;
    genvar k;
    generate
        for (k = 0; k < 4; k = k + 1) begin : g_lane
            // Wide mode: lane 0 hi*hi, 1 hi*lo, 2 lo*hi, 3 lo*lo; low halves unsigned
            wire wide = (mode_s[2*(k/2) +: 2] == `MB_MODE_WIDE);
            wire [17:0] a_w = (k < 2) ? opa_s[35:18] : opa_s[17:0];
            wire [17:0] b_w = (k % 2 == 0) ? opb_s[35:18] : opb_s[17:0];
            wire sa_w = (k < 2) ? sa_s[0] : 1'b0;
            wire sb_w = (k % 2 == 0) ? sb_s[0] : 1'b0;
            wire [17:0] a = wide ? a_w : opa_s[18*k +: 18];
            wire [17:0] b = wide ? b_w : opb_s[18*k +: 18];
            wire sa = wide ? sa_w : sa_s[k/2];
            wire sb = wide ? sb_w : sb_s[k/2];
            wire [37:0] p18 = mul18(a, b, sa, sb);
            wire [17:0] p9_lo = mul9(a[8:0], b[8:0], sa, sb);
            wire [17:0] p9_hi = mul9(a[17:9], b[17:9], sa, sb);
            assign lane_res[38*k +: 38] = (mode_s[2*(k/2) +: 2] == `MB_MODE_NINE) ?
                {2'b00, p9_hi, p9_lo} : p18;
        end
    endgenerate

    // ----------------------------------------------------------------
    // Pipeline stage after the multipliers (optional)
    // ----------------------------------------------------------------
    reg [151:0] lane_r;
    reg [3:0] mode_pr;
    reg [1:0] dir_pr;
    reg [1:0] signed_pr;
    always @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            lane_r <= 152'h0;
            mode_pr <= 4'h0;
            dir_pr <= 2'h0;
            signed_pr <= 2'h0;
        end else if (clk_en_in) begin
            lane_r <= lane_res;
            mode_pr <= mode_s;
            dir_pr <= dir_s;
            signed_pr <= sa_s | sb_s;
        end
    end

    wire [151:0] lane_p = pipe_en ? lane_r : lane_res;
    wire [3:0] mode_p = pipe_en ? mode_pr : mode_s;
    wire [1:0] dir_p = pipe_en ? dir_pr : dir_s;
    wire [1:0] signed_p = pipe_en ? signed_pr : (sa_s | sb_s);

    // ----------------------------------------------------------------
    // Summation of partial products for the 72-bit result
    // ----------------------------------------------------------------
    wire [71:0] e0 = {{34{lane_p[37]}}, lane_p[37:0]};
    wire [71:0] e1 = {{34{lane_p[75]}}, lane_p[75:38]};
    wire [71:0] e2 = {{34{lane_p[113]}}, lane_p[113:76]};
    wire [71:0] e3 = {{34{lane_p[151]}}, lane_p[151:114]};
    wire [71:0] wide_sum = (e0 << 36) + ((e1 + e2) << 18) + e3;
    wire wide_p = (mode_p[1:0] == `MB_MODE_WIDE);

    // ----------------------------------------------------------------
    // Load-select delay line
    // ----------------------------------------------------------------
    reg [1:0] load_d1_r;
    reg [1:0] load_d2_r;
    always @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            load_d1_r <= 2'h0;
            load_d2_r <= 2'h0;
        end else if (clk_en_in) begin
            load_d1_r <= accum_load_in;
            load_d2_r <= load_d1_r;
        end
    end
    wire [1:0] load_p = (load_dly == 2'h0) ? accum_load_in :
        (load_dly == 2'h1) ? load_d1_r : load_d2_r;

    // ----------------------------------------------------------------
    // Output registers, products and accumulators
    // ----------------------------------------------------------------
    reg [143:0] product_r;
    reg [103:0] acc_r;
    reg [1:0] ovf_det_r;
    reg [1:0] ovf_r;
    reg [103:0] acc_nxt;
    reg [1:0] ovf_det_nxt;
    reg [53:0] fb;
    reg [53:0] pv;
    reg [53:0] s;
    integer c;
    always @* begin
        acc_nxt = acc_r;
        ovf_det_nxt = 2'h0;
        fb = 54'h0;
        pv = 54'h0;
        s = 54'h0;
        for (c = 0; c < 2; c = c + 1) begin
            if (mode_p[2*c +: 2] == `MB_MODE_MAC) begin
                // Channel c uses the first multiplier of its half
                pv = {{16{lane_p[76*c+37]}}, lane_p[76*c +: 38]};
                if (load_p[c]) begin
                    // Preload upper bits; zero preload means a fresh sum
                    fb = {18'h0, preload_in[36*c +: 36]} << 16;
                end else if (signed_p[c]) begin
                    fb = {{2{acc_r[52*c+51]}}, acc_r[52*c +: 52]};
                end else begin
                    fb = {2'b00, acc_r[52*c +: 52]};
                end
                if (dir_p[c]) begin
                    s = fb + pv;
                end else begin
                    s = fb - pv;
                end
                acc_nxt[52*c +: 52] = s[51:0];
                if (signed_p[c]) begin
                    ovf_det_nxt[c] = (s[53:51] != 3'b000) && (s[53:51] != 3'b111);
                end else begin
                    ovf_det_nxt[c] = (s[53:52] != 2'b00);
                end
            end
        end
    end

    integer q;
    always @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            product_r <= 144'h0;
            acc_r <= 104'h0;
            ovf_det_r <= 2'h0;
            ovf_r <= 2'h0;
        end else if (clk_en_in) begin
            if (clear_r) begin
                // Accumulator state lives in the output registers
                product_r <= 144'h0;
                acc_r <= 104'h0;
                ovf_det_r <= 2'h0;
                ovf_r <= 2'h0;
            end else begin
                if (wide_p) begin
                    product_r <= {72'h0, wide_sum};
                end else begin
                    for (q = 0; q < 4; q = q + 1) begin
                        product_r[36*q +: 36] <= lane_p[38*q +: 36];
                    end
                end
                acc_r <= acc_nxt;
                ovf_det_r <= ovf_det_nxt;
                // Pulse only on a new detection, not while it persists
                ovf_r <= ovf_det_nxt & ~ovf_det_r;
            end
        end
    end

    assign product_out = product_r;
    assign accum_out = acc_r;
    assign overflow_out = ovf_r;
    assign status_w = {26'h0000000, ovf_r, mode_now};

endmodule // mult_block

// >>> verif/mult_block_monitor.sv
// Purpose: Port-level assertions for mult_block
// Assumes: One clock domain; reset_n_in asynchronous, active low
// Notes:   Datapath latency hangs on CTRL, so only latency-free relations are tied here
`timescale 1ns/100ps
module mult_block_monitor (
    // Clock, reset, enable
    input wire clk_sys_in,
    input wire reset_n_in,
    input wire clk_en_in,
    // Register bus
    input wire awvalid_in,
    input wire awready_out,
    input wire wvalid_in,
    input wire wready_out,
    input wire bvalid_out,
    input wire bready_in,
    input wire [1:0] bresp_out,
    input wire arvalid_in,
    input wire arready_out,
    input wire rvalid_out,
    input wire rready_in,
    input wire [31:0] rdata_out,
    // Results
    input wire [143:0] product_out,
    input wire [103:0] accum_out,
    input wire [1:0] overflow_out
);
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!reset_n_in);
    sequence wr_taken;
        awvalid_in && awready_out && wvalid_in && wready_out;
    endsequence
    sequence rd_taken;
        arvalid_in && arready_out;
    endsequence
    a_write_answer: assert property (wr_taken |=> bvalid_out)
        else $error("write response missing");
    a_bresp_holds: assert property (bvalid_out && !bready_in |=> bvalid_out && $stable(bresp_out))
        else $error("write response dropped early");
    a_read_answer: assert property (rd_taken |=> rvalid_out)
        else $error("read data missing");
    a_rdata_holds: assert property (rvalid_out && !rready_in |=> rvalid_out && $stable(rdata_out))
        else $error("read data dropped early");
    a_read_refused: assert property (rvalid_out |-> !arready_out)
        else $error("read taken while one pends");
    a_enable_refuses: assert property (!clk_en_in |-> !awready_out && !wready_out && !arready_out)
        else $error("bus taken while disabled");
    a_output_held: assert property (!clk_en_in |=> $stable(accum_out) && $stable(product_out))
        else $error("results moved while disabled");
    a_ovf_pulse0: assert property (overflow_out[0] |=> !overflow_out[0])
        else $error("overflow 0 longer than one cycle");
    a_ovf_pulse1: assert property (overflow_out[1] |=> !overflow_out[1])
        else $error("overflow 1 longer than one cycle");
endmodule // mult_block_monitor

bind mult_block mult_block_monitor u_monitor (
    .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .clk_en_in(clk_en_in),
    .awvalid_in(awvalid_in), .awready_out(awready_out), .wvalid_in(wvalid_in), .wready_out(wready_out),
    .bvalid_out(bvalid_out), .bready_in(bready_in), .bresp_out(bresp_out),
    .arvalid_in(arvalid_in), .arready_out(arready_out), .rvalid_out(rvalid_out),
    .rready_in(rready_in), .rdata_out(rdata_out),
    .product_out(product_out), .accum_out(accum_out), .overflow_out(overflow_out)
);

// >>> verif/fabric_model.sv
// Purpose: Surrounding logic that feeds the multiplier block
// Assumes: Requests come from the bench just after a rising edge
// Notes:   Keeps the obligations that fall on the feeding side
`timescale 1ns/100ps
`include "mult_block_defs.vh"
module fabric_model (
    // Clock and reset
    input wire clk_sys_in,
    input wire reset_n_in,
    // Requests
    input wire wide_req_in,
    input wire narrow_acc_in,
    input wire [3:0] mode_req_in,
    input wire [71:0] opa_req_in,
    input wire [1:0] overflow_in,
    // Toward the block
    output wire [3:0] half_mode_out,
    output wire [71:0] opa_out,
    output reg [1:0] ovf_sticky_out
);
    // A 36-bit product owns the whole block, so both halves switch together
    assign half_mode_out = wide_req_in ? {`MB_MODE_WIDE, `MB_MODE_WIDE} : mode_req_in;
    // Ten-bit accumulators: unused low operand bits of each channel lane go to zero
    assign opa_out = narrow_acc_in ? opa_req_in & ~{2{18'h0, 18'h000ff}} : opa_req_in;
    // Overflow only pulses, so the fabric keeps a sticky copy
    always @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ovf_sticky_out <= 2'h0;
        end else begin
            ovf_sticky_out <= ovf_sticky_out | overflow_in;
        end
    end
endmodule // fabric_model

// >>> verif/mult_block_tb.sv
// Purpose: Self-checking bench for mult_block
// Assumes: CTRL at zero gives one cycle from operands to results
// Notes:   Checks run 1 ns after a rising edge
`timescale 1ns/100ps
`include "mult_block_defs.vh"
module mult_block_tb;
    reg clk = 1'h0, rst_n = 1'h0, en = 1'h1, awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0, rry = 1'h0;
    reg wide = 1'h0, nacc = 1'h0;
    reg [7:0] awa = 8'h0, ara = 8'h0;
    reg [31:0] wd = 32'h0, data;
    reg [71:0] opa = 72'h0, opb = 72'h0, pre = 72'h0, e;
    reg [1:0] sa = 2'h0, sb = 2'h0, dir = 2'h0, ld = 2'h0, resp;
    reg [3:0] mode = 4'h0;
    reg [143:0] keep;
    wire awr, wr, bv, arr, rv;
    wire [1:0] br, rr, ovf, sticky;
    wire [31:0] rd;
    wire [3:0] hm;
    wire [71:0] opf;
    wire [143:0] prod;
    wire [103:0] acc;
    integer error_cnt = 0, samples_checked = 0, i, j;
    mult_block dut (
        .clk_sys_in(clk), .reset_n_in(rst_n), .clk_en_in(en),
        .awvalid_in(awv), .awready_out(awr), .awaddr_in(awa),
        .wvalid_in(wv), .wready_out(wr), .wdata_in(wd), .wstrb_in(4'hf),
        .bvalid_out(bv), .bready_in(bry), .bresp_out(br),
        .arvalid_in(arv), .arready_out(arr), .araddr_in(ara),
        .rvalid_out(rv), .rready_in(rry), .rdata_out(rd), .rresp_out(rr),
        .opa_in(opf), .opb_in(opb), .sign_a_in(sa), .sign_b_in(sb), .half_mode_in(hm),
        .accum_dir_in(dir), .accum_load_in(ld), .preload_in(pre),
        .product_out(prod), .accum_out(acc), .overflow_out(ovf)
    );
    fabric_model fab (
        .clk_sys_in(clk), .reset_n_in(rst_n), .wide_req_in(wide), .narrow_acc_in(nacc),
        .mode_req_in(mode), .opa_req_in(opa), .overflow_in(ovf),
        .half_mode_out(hm), .opa_out(opf), .ovf_sticky_out(sticky)
    );
    initial begin
        forever #2 clk = ~clk;
    end
    function [71:0] mulx(input [35:0] a, input [35:0] b, input s_a, input s_b);
        mulx = $signed({s_a & a[35], a}) * $signed({s_b & b[35], b});
    endfunction
    function [35:0] sx(input [35:0] v, input integer w, input s);
        sx = (s && v[w-1]) ? v | (~36'h0 << w) : v;
    endfunction
    task chk(input [143:0] got, input [143:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task report_and_stop;
        begin
            $display("checks %0d errors %0d", samples_checked, error_cnt);
            if (error_cnt == 0 && samples_checked > 0) $display("TEST PASSED");
            else $display("TEST FAILED");
            $finish;
        end
    endtask
    task step;
        begin
            @(posedge clk);
            #1;
        end
    endtask
    // Handshakes judged at the falling edge; inputs move only after rising edges
    task bus(input w, input [7:0] a, input [31:0] d);
        integer n;
        reg ah, wh, rh, fin, done;
        begin
            if (w) begin
                awa <= a; wd <= d; awv <= 1'h1; wv <= 1'h1; bry <= 1'h1;
            end else begin
                ara <= a; arv <= 1'h1; rry <= 1'h1;
            end
            n = 0;
            done = 1'h0;
            while (!done && n < 100) begin
                @(negedge clk);
                ah = awv && awr; wh = wv && wr; rh = arv && arr;
                fin = (bv && bry) || (rv && rry);
                resp = bv ? br : rr; data = rd;
                @(posedge clk);
                n = n + 1;
                if (ah) awv <= 1'h0;
                if (wh) wv <= 1'h0;
                if (rh) arv <= 1'h0;
                if (fin) begin
                    bry <= 1'h0; rry <= 1'h0; done = 1'h1;
                end
            end
            #1;
            if (!done) begin
                error_cnt = error_cnt + 1;
                $display("CHECK FAILED t=%0t bus answer timed out", $time);
                report_and_stop;
            end
        end
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'h1;
        #1;
        bus(1'h0, `MB_OFS_CTRL, 32'h0);
        chk(data, `MB_CTRL_RESET);
        bus(1'h1, `MB_OFS_CTRL, 32'hffff);
        bus(1'h0, `MB_OFS_CTRL, 32'h0);
        chk(data, `MB_CTRL_MASK);
        bus(1'h1, `MB_OFS_STATUS, 32'hffff);
        chk(resp, `MB_RESP_OKAY);
        bus(1'h0, 8'h08, 32'h0);
        chk({resp, data}, {`MB_RESP_SLVERR, 32'h0});
        bus(1'h1, 8'h08, 32'h0);
        chk(resp, `MB_RESP_SLVERR);
        opa <= {18'h3fffe, 18'h20001, 18'h00007, 18'h1ffff};
        opb <= {18'h3ffff, 18'h2aaaa, 18'h3fff9, 18'h20000};
        mode <= 4'h5; sa <= 2'h1; sb <= 2'h3;
        bus(1'h1, `MB_OFS_CTRL, 32'h60);
        bus(1'h0, `MB_OFS_STATUS, 32'h0);
        chk(data[3:0], 4'hf);
        for (i = 0; i < 8; i = i + 1) begin
            e = mulx(sx(opa[9*i +: 9], 9, sa[i/4]), sx(opb[9*i +: 9], 9, sb[i/4]), 1'h1, 1'h1);
            chk(prod[18*i +: 18], e[17:0]);
        end
        bus(1'h1, `MB_OFS_CTRL, 32'h0);
        mode <= 4'h0;
        for (j = 0; j < 2; j = j + 1) begin
            sa <= j ? 2'h2 : 2'h1; sb <= j ? 2'h1 : 2'h3;
            step;
            for (i = 0; i < 4; i = i + 1) begin
                e = mulx(sx(opa[18*i +: 18], 18, sa[i/2]), sx(opb[18*i +: 18], 18, sb[i/2]), 1'h1, 1'h1);
                chk(prod[36*i +: 36], e[35:0]);
            end
        end
        keep = prod;
        en <= 1'h0; opa <= ~opa;
        repeat (2) step;
        chk(prod, keep);
        en <= 1'h1; wide <= 1'h1;
        opa <= {36'h0, 36'h800000003}; opb <= {36'h0, 36'hfffffff05};
        for (j = 0; j < 4; j = j + 1) begin
            sa <= {1'h0, j[0]}; sb <= {1'h0, j[1]};
            step;
            e = mulx(opa[35:0], opb[35:0], j[0], j[1]);
            chk(prod, {72'h0, e});
        end
        wide <= 1'h0; mode <= 4'h1; sa <= 2'h1; sb <= 2'h1; dir <= 2'h1; ld <= 2'h1;
        pre <= {36'h0, 36'h3};
        opa <= {18'h0, 18'h004d2, 18'h0, 18'h3fffb}; opb <= {18'h0, 18'h0000a, 18'h0, 18'h00007};
        step;
        chk(acc[51:0], 52'h2ffdd);
        chk(prod[107:72], 36'h03034);
        ld <= 2'h0; dir <= 2'h0; nacc <= 1'h1; opa[17:0] <= 18'h001ff; opb[17:0] <= 18'h3fffd;
        step;
        chk(acc[51:0], 52'h302dd);
        nacc <= 1'h0; ld <= 2'h1; dir <= 2'h1; pre <= 72'h0; opa[17:0] <= 18'h00006; opb[17:0] <= 18'h00001;
        step;
        chk(acc[51:0], 52'h6);
        mode <= 4'h0; ld <= 2'h0;
        bus(1'h1, `MB_OFS_CTRL, 32'h100);
        chk(acc, 104'h0);
        mode <= 4'h5; sa <= 2'h0; sb <= 2'h0; dir <= 2'h3; ld <= 2'h3; pre <= ~72'h0;
        opa <= {2{18'h0, 18'h10000}}; opb <= {2{18'h0, 18'h00001}};
        step;
        chk(ovf, 2'h3);
        step;
        chk({sticky, ovf}, 4'hc);
        mode <= 4'h0; opa <= 72'h0; opb <= 72'h1; bus(1'h1, `MB_OFS_CTRL, 32'h3);
        opa <= 72'h5; repeat (2) step; chk(prod[35:0], 36'h0); step; chk(prod[35:0], 36'h5);
        report_and_stop;
    end
endmodule // mult_block_tb
